// ===== pmx_regs.svh
`ifndef PMX_REGS_SVH
`define PMX_REGS_SVH

// register byte addresses on the bus
`define PMX_ADR_PORT_ZERO 8'h00
`define PMX_ADR_PORT_ONE 8'h04
`define PMX_ADR_PORT_TWO 8'h08
`define PMX_ADR_PORT_THREE 8'h0c
`define PMX_ADR_PORT_FOUR 8'h10
`define PMX_ADR_PWM_OE 8'h14
`define PMX_ADR_ADC_CONN 8'h18
`define PMX_ADR_CSC_ZERO 8'h1c
`define PMX_ADR_CSC_ONE 8'h20
`define PMX_ADR_RMW_CMD 8'h24
`define PMX_ADR_RMW_RES 8'h28

// reset values
`define PMX_LATCH_RST 8'hff
`define PMX_PWM_OE_RST 8'h00
`define PMX_ADC_CONN_RST 4'h0
`define PMX_CSC_ZERO_RST 3'h0
`define PMX_CSC_ONE_RST 4'h0
`define PMX_RMW_RES_RST 16'hffff

// chip setup control zero fields
`define PMX_CS0_ODD_EVEN_SEL 0
`define PMX_CS0_VSYNC_OE 1
`define PMX_CS0_VSYNC_ALT 2

// chip setup control one fields
`define PMX_CS1_ADDR17_SEL 0
`define PMX_CS1_ADDR18_SEL 1
`define PMX_CS1_ADDR19_SEL 2
`define PMX_CS1_STROBE_EN 3

// latch array index of each latched port
`define PMX_IDX_ZERO 2'h0
`define PMX_IDX_ONE 2'h1
`define PMX_IDX_THREE 2'h2
`define PMX_IDX_FOUR 2'h3

// port three pin positions
`define PMX_P3_ODD_EVEN 0
`define PMX_P3_XINT0_TXD 1
`define PMX_P3_INT0 2
`define PMX_P3_INT1 3
`define PMX_P3_T0 4
`define PMX_P3_T1 5
`define PMX_P3_XINT1_RXD 7

// port four pin positions
`define PMX_P4_ADDR17 0
`define PMX_P4_ADDR18 1
`define PMX_P4_RD 2
`define PMX_P4_WR 3
`define PMX_P4_ADDR19 4
`define PMX_P4_VSYNC 7

// read-modify-write command fields
`define PMX_CMD_OPND_LSB 0
`define PMX_CMD_BIT_LSB 8
`define PMX_CMD_PORT_LSB 11
`define PMX_CMD_OP_LSB 13

`endif

// ===== pmx_pkg.sv
package pmx_pkg;

  // read-modify-write operations applied to a port latch
  typedef enum logic [3:0] {
    PMX_OP_AND,
    PMX_OP_OR,
    PMX_OP_XOR,
    PMX_OP_INC,
    PMX_OP_DEC,
    PMX_OP_CPL_BIT,
    PMX_OP_CLR_BIT,
    PMX_OP_SET_BIT,
    PMX_OP_MOV_BIT,
    PMX_OP_JBC
  } pmx_rmw_op_t;

  // whole state of the routing block
  typedef struct packed {
    logic [3:0][7:0] latch;
    logic [3:0][7:0] pull;
    logic [3:0][7:0] pad_out;
    logic [3:0][7:0] pad_oe_n;
    logic [7:0] pwm_oe;
    logic [3:0] adc_conn;
    logic [2:0] csc_zero;
    logic [3:0] csc_one;
    logic [15:0] rmw_res;
    logic ack;
    logic [31:0] dat;
    logic [3:0] adc_conn_out;
    logic int0_n;
    logic int1_n;
    logic xint0_n;
    logic xint1_n;
    logic t0_in;
    logic t1_in;
    logic rxd;
    logic vsync_in;
  } pmx_state_t;

endpackage

// ===== pmx_sync.sv
`timescale 1ns/10ps
`default_nettype none

module pmx_sync #(
  parameter int WIDTH = 36,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // asynchronous levels in, clean levels out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } pmx_sync_state_t;

  pmx_sync_state_t s_q;
  pmx_sync_state_t s_d;

  // two stages; only the second stage is ever looked at
  always_comb begin
    s_d = s_q;
    s_d.meta = async_i;
    s_d.stable = s_q.meta;
  end

  // reset to idle-high so no false events follow reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= {RST_VAL, RST_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_o = s_q.stable;

endmodule

`default_nettype wire

// ===== pmx_port_mux.sv
// How it works
// - pwm enable bit routes port one pins 0-5 to 8-bit, 6-7 to 14-bit pwm.
// - port two pins 0-3 feed adc channels when connect bit set, else plain inputs.
// - port three pin 0 outputs odd/even indicator when its select bit is set.
// - port three pin 1: extra interrupt 0 in input mode, serial transmit in output mode.
// - port three pin 7 feeds extra interrupt 1 and serial receive in input mode.
// - port three pins 2 and 3 deliver interrupts 0 and 1 in input mode.
// - port three pins 4 and 5 deliver timer 0 and 1 count inputs in input mode.
// - port four pins 0,1,4 drive address lines 17-19 until select bit makes them pins.
// - port four pins 2,3 are pins until strobe enable routes read/write strobes.
// - port four pin 7 is a pin/vsync input; setup bits pick vsync or odd/even out.
// - read-modify-write on a port takes its operand from the latch, not the pin.
// - bit operations read whole latch byte, change one bit, write the byte back.
// - latch reading covers and, or, xor, jbc, cpl, inc, dec, djnz, bit mov/clr/set; pmx_rmw_op_t has no djnz op.
// - every port latch resets to all ones, so pins start as inputs, save port four pins 0,1,4 driving address lines.
// - a plain port read returns latch value anded with the pin level.
// - port three control inputs are produced only while the latch bit is one.
// - quasi ports drive strong high one clock only on a latch zero-to-one change.
//
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "pmx_regs.svh"

module pmx_port_mux (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // port zero pads, open drain
  input wire logic [7:0] port_zero_i,
  output logic [7:0] port_zero_o,
  output logic [7:0] port_zero_oe_n_o,
  // port one pads, quasi-bidirectional
  input wire logic [7:0] port_one_i,
  output logic [7:0] port_one_o,
  output logic [7:0] port_one_oe_n_o,
  // port two pads, input only
  input wire logic [3:0] port_two_i,
  // port three pads, quasi-bidirectional
  input wire logic [7:0] port_three_i,
  output logic [7:0] port_three_o,
  output logic [7:0] port_three_oe_n_o,
  // port four pads, quasi-bidirectional
  input wire logic [7:0] port_four_i,
  output logic [7:0] port_four_o,
  output logic [7:0] port_four_oe_n_o,
  // signals from peripherals to be routed out
  input wire logic [5:0] pwm8_i,
  input wire logic [1:0] pwm14_i,
  input wire logic odd_even_i,
  input wire logic txd_i,
  input wire logic [2:0] addr_hi_i,
  input wire logic rd_strobe_n_i,
  input wire logic wr_strobe_n_i,
  input wire logic vsync_i,
  // signals routed in to peripherals
  output logic [3:0] adc_connect_o,
  output logic int0_n_o,
  output logic int1_n_o,
  output logic xint0_n_o,
  output logic xint1_n_o,
  output logic t0_count_o,
  output logic t1_count_o,
  output logic rxd_o,
  output logic vsync_in_o
);

  localparam int SYNC_W = 36;

  pmx_pkg::pmx_state_t s_q;
  pmx_pkg::pmx_state_t s_d;
  logic [SYNC_W-1:0] pins_sync;
  logic [7:0] p0_s;
  logic [7:0] p1_s;
  logic [3:0] p2_s;
  logic [7:0] p3_s;
  logic [7:0] p4_s;

  // byte lane merge for narrow registers
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [7:0] wr,
                                       input logic sel);
    lane0 = sel ? wr : old;
  endfunction

  // latch and pin combined for a plain port read
  function automatic logic [31:0] port_rd(input logic [7:0] latch, input logic [7:0] pin);
    port_rd = {24'h000000, latch & pin};
  endfunction

  // operand comes from the latch value, never from the pins
  function automatic logic [7:0] rmw(input pmx_pkg::pmx_rmw_op_t op, input logic [7:0] old,
                                     input logic [7:0] opnd, input logic [2:0] bidx);
    logic [7:0] one;
    one = 8'h01 << bidx;
    case (op)
      pmx_pkg::PMX_OP_AND: rmw = old & opnd;
      pmx_pkg::PMX_OP_OR: rmw = old | opnd;
      pmx_pkg::PMX_OP_XOR: rmw = old ^ opnd;
      pmx_pkg::PMX_OP_INC: rmw = old + 8'h01;
      pmx_pkg::PMX_OP_DEC: rmw = old - 8'h01;
      pmx_pkg::PMX_OP_CPL_BIT: rmw = old ^ one;
      pmx_pkg::PMX_OP_CLR_BIT: rmw = old & ~one;
      pmx_pkg::PMX_OP_SET_BIT: rmw = old | one;
      pmx_pkg::PMX_OP_MOV_BIT: rmw = opnd[0] ? (old | one) : (old & ~one);
      pmx_pkg::PMX_OP_JBC: rmw = old & ~one;
      default: rmw = old;
    endcase
  endfunction

  // external levels arrive unsynchronised
  pmx_sync #(
    .WIDTH(SYNC_W),
    .RST_VAL({SYNC_W{1'b1}})
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({port_four_i, port_three_i, port_two_i, port_one_i, port_zero_i}),
    .sync_o(pins_sync)
  );

  assign p0_s = pins_sync[7:0];
  assign p1_s = pins_sync[15:8];
  assign p2_s = pins_sync[19:16];
  assign p3_s = pins_sync[27:20];
  assign p4_s = pins_sync[35:28];

  // bus access, latch updates, pad and routing decisions
  always_comb begin
    logic req;
    logic [7:0] adr;
    logic [1:0] pidx;
    logic [7:0] old;
    logic [7:0] nxt;
    logic [3:0][7:0] alt_en;
    logic [3:0][7:0] alt_val;
    logic [7:0] p2_rd;
    logic [7:0] l3;
    req = 1'b0;
    adr = 8'h00;
    pidx = 2'h0;
    old = 8'h00;
    nxt = 8'h00;
    alt_en = '0;
    alt_val = '0;
    p2_rd = 8'h00;
    l3 = 8'h00;
    s_d = s_q;

    // single-cycle answer; ack drops the cycle after it was given
    req = wb_cyc_i & wb_stb_i & ~s_q.ack;
    s_d.ack = req;
    adr = {wb_adr_i[7:2], 2'b00};
    p2_rd = {4'h0, p2_s & ~s_q.adc_conn};
    if (req) begin
      s_d.dat = 32'h00000000;
      if (wb_we_i) begin
        case (adr)
          `PMX_ADR_PORT_ZERO: s_d.latch[`PMX_IDX_ZERO] =
            lane0(s_q.latch[`PMX_IDX_ZERO], wb_dat_i[7:0], wb_sel_i[0]);
          `PMX_ADR_PORT_ONE: s_d.latch[`PMX_IDX_ONE] =
            lane0(s_q.latch[`PMX_IDX_ONE], wb_dat_i[7:0], wb_sel_i[0]);
          `PMX_ADR_PORT_THREE: s_d.latch[`PMX_IDX_THREE] =
            lane0(s_q.latch[`PMX_IDX_THREE], wb_dat_i[7:0], wb_sel_i[0]);
          `PMX_ADR_PORT_FOUR: s_d.latch[`PMX_IDX_FOUR] =
            lane0(s_q.latch[`PMX_IDX_FOUR], wb_dat_i[7:0], wb_sel_i[0]);
          `PMX_ADR_PWM_OE: s_d.pwm_oe = lane0(s_q.pwm_oe, wb_dat_i[7:0], wb_sel_i[0]);
          `PMX_ADR_ADC_CONN: s_d.adc_conn = wb_sel_i[0] ? wb_dat_i[3:0] : s_q.adc_conn;
          `PMX_ADR_CSC_ZERO: s_d.csc_zero = wb_sel_i[0] ? wb_dat_i[2:0] : s_q.csc_zero;
          `PMX_ADR_CSC_ONE: s_d.csc_one = wb_sel_i[0] ? wb_dat_i[3:0] : s_q.csc_one;
          `PMX_ADR_RMW_CMD: begin
            // whole byte is read from latch, modified and written back
            if (wb_sel_i[1:0] == 2'b11) begin
              pidx = wb_dat_i[`PMX_CMD_PORT_LSB +: 2];
              old = s_q.latch[pidx];
              nxt = rmw(pmx_pkg::pmx_rmw_op_t'(wb_dat_i[`PMX_CMD_OP_LSB +: 4]), old,
                        wb_dat_i[`PMX_CMD_OPND_LSB +: 8],
                        wb_dat_i[`PMX_CMD_BIT_LSB +: 3]);
              s_d.latch[pidx] = nxt;
              s_d.rmw_res = {nxt, old};
            end
          end
          default: ; // unmapped or read-only: write ignored
        endcase
      end else begin
        case (adr)
          `PMX_ADR_PORT_ZERO: s_d.dat = port_rd(s_q.latch[`PMX_IDX_ZERO], p0_s);
          `PMX_ADR_PORT_ONE: s_d.dat = port_rd(s_q.latch[`PMX_IDX_ONE], p1_s);
          `PMX_ADR_PORT_TWO: s_d.dat = port_rd(8'hff, p2_rd);
          `PMX_ADR_PORT_THREE: s_d.dat = port_rd(s_q.latch[`PMX_IDX_THREE], p3_s);
          `PMX_ADR_PORT_FOUR: s_d.dat = port_rd(s_q.latch[`PMX_IDX_FOUR], p4_s);
          `PMX_ADR_PWM_OE: s_d.dat = {24'h000000, s_q.pwm_oe};
          `PMX_ADR_ADC_CONN: s_d.dat = {28'h0000000, s_q.adc_conn};
          `PMX_ADR_CSC_ZERO: s_d.dat = {29'h00000000, s_q.csc_zero};
          `PMX_ADR_CSC_ONE: s_d.dat = {28'h0000000, s_q.csc_one};
          `PMX_ADR_RMW_RES: s_d.dat = {16'h0000, s_q.rmw_res};
          default: s_d.dat = 32'h00000000;
        endcase
      end
    end

    // strong high only after a zero-to-one latch change, for one clock
    s_d.pull = ~s_q.latch & s_d.latch;

    // port one alternates: pwm channels
    alt_en[`PMX_IDX_ONE] = s_q.pwm_oe;
    alt_val[`PMX_IDX_ONE] = {pwm14_i, pwm8_i};

    // port three alternates; pin 6 has none
    l3 = s_q.latch[`PMX_IDX_THREE];
    alt_en[`PMX_IDX_THREE][`PMX_P3_ODD_EVEN] = s_q.csc_zero[`PMX_CS0_ODD_EVEN_SEL];
    alt_val[`PMX_IDX_THREE][`PMX_P3_ODD_EVEN] = odd_even_i;
    alt_en[`PMX_IDX_THREE][`PMX_P3_XINT0_TXD] = ~l3[`PMX_P3_XINT0_TXD];
    alt_val[`PMX_IDX_THREE][`PMX_P3_XINT0_TXD] = txd_i;

    // port four alternates: address lines by default, strobes and sync on request
    alt_en[`PMX_IDX_FOUR][`PMX_P4_ADDR17] = ~s_q.csc_one[`PMX_CS1_ADDR17_SEL];
    alt_en[`PMX_IDX_FOUR][`PMX_P4_ADDR18] = ~s_q.csc_one[`PMX_CS1_ADDR18_SEL];
    alt_en[`PMX_IDX_FOUR][`PMX_P4_ADDR19] = ~s_q.csc_one[`PMX_CS1_ADDR19_SEL];
    alt_val[`PMX_IDX_FOUR][`PMX_P4_ADDR17] = addr_hi_i[0];
    alt_val[`PMX_IDX_FOUR][`PMX_P4_ADDR18] = addr_hi_i[1];
    alt_val[`PMX_IDX_FOUR][`PMX_P4_ADDR19] = addr_hi_i[2];
    alt_en[`PMX_IDX_FOUR][`PMX_P4_RD] = s_q.csc_one[`PMX_CS1_STROBE_EN];
    alt_en[`PMX_IDX_FOUR][`PMX_P4_WR] = s_q.csc_one[`PMX_CS1_STROBE_EN];
    alt_val[`PMX_IDX_FOUR][`PMX_P4_RD] = rd_strobe_n_i;
    alt_val[`PMX_IDX_FOUR][`PMX_P4_WR] = wr_strobe_n_i;
    alt_en[`PMX_IDX_FOUR][`PMX_P4_VSYNC] = s_q.csc_zero[`PMX_CS0_VSYNC_OE];
    alt_val[`PMX_IDX_FOUR][`PMX_P4_VSYNC] =
      s_q.csc_zero[`PMX_CS0_VSYNC_ALT] ? odd_even_i : vsync_i;

    // port zero: open drain, no alternates at all
    s_d.pad_out[`PMX_IDX_ZERO] = 8'h00;
    s_d.pad_oe_n[`PMX_IDX_ZERO] = s_q.latch[`PMX_IDX_ZERO];

    // quasi ports: pull low on zero, pulse high on rising latch, push-pull alternates
    for (int k = 1; k < 4; k++) begin
      for (int b = 0; b < 8; b++) begin
        if (alt_en[k][b]) begin
          s_d.pad_out[k][b] = alt_val[k][b];
          s_d.pad_oe_n[k][b] = 1'b0;
        end else begin
          s_d.pad_out[k][b] = s_q.latch[k][b];
          s_d.pad_oe_n[k][b] = s_q.latch[k][b] & ~s_q.pull[k][b];
        end
      end
    end

    // port three control inputs only while the latch bit holds one
    s_d.xint0_n = l3[`PMX_P3_XINT0_TXD] ? p3_s[`PMX_P3_XINT0_TXD] : 1'b1;
    s_d.int0_n = l3[`PMX_P3_INT0] ? p3_s[`PMX_P3_INT0] : 1'b1;
    s_d.int1_n = l3[`PMX_P3_INT1] ? p3_s[`PMX_P3_INT1] : 1'b1;
    s_d.t0_in = l3[`PMX_P3_T0] ? p3_s[`PMX_P3_T0] : 1'b1;
    s_d.t1_in = l3[`PMX_P3_T1] ? p3_s[`PMX_P3_T1] : 1'b1;
    s_d.xint1_n = l3[`PMX_P3_XINT1_RXD] ? p3_s[`PMX_P3_XINT1_RXD] : 1'b1;
    s_d.rxd = l3[`PMX_P3_XINT1_RXD] ? p3_s[`PMX_P3_XINT1_RXD] : 1'b1;
    s_d.vsync_in = p4_s[`PMX_P4_VSYNC];
    s_d.adc_conn_out = s_q.adc_conn;
  end

  // all state in one register; latches preset to ones
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q.latch <= {4{`PMX_LATCH_RST}};
      s_q.pull <= '0;
      s_q.pad_out <= '0;
      s_q.pad_oe_n <= '1;
      s_q.pwm_oe <= `PMX_PWM_OE_RST;
      s_q.adc_conn <= `PMX_ADC_CONN_RST;
      s_q.csc_zero <= `PMX_CSC_ZERO_RST;
      s_q.csc_one <= `PMX_CSC_ONE_RST;
      s_q.rmw_res <= `PMX_RMW_RES_RST;
      s_q.ack <= 1'b0;
      s_q.dat <= 32'h00000000;
      s_q.adc_conn_out <= `PMX_ADC_CONN_RST;
      s_q.int0_n <= 1'b1;
      s_q.int1_n <= 1'b1;
      s_q.xint0_n <= 1'b1;
      s_q.xint1_n <= 1'b1;
      s_q.t0_in <= 1'b1;
      s_q.t1_in <= 1'b1;
      s_q.rxd <= 1'b1;
      s_q.vsync_in <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign wb_dat_o = s_q.dat;
  assign wb_ack_o = s_q.ack;
  assign port_zero_o = s_q.pad_out[`PMX_IDX_ZERO];
  assign port_zero_oe_n_o = s_q.pad_oe_n[`PMX_IDX_ZERO];
  assign port_one_o = s_q.pad_out[`PMX_IDX_ONE];
  assign port_one_oe_n_o = s_q.pad_oe_n[`PMX_IDX_ONE];
  assign port_three_o = s_q.pad_out[`PMX_IDX_THREE];
  assign port_three_oe_n_o = s_q.pad_oe_n[`PMX_IDX_THREE];
  assign port_four_o = s_q.pad_out[`PMX_IDX_FOUR];
  assign port_four_oe_n_o = s_q.pad_oe_n[`PMX_IDX_FOUR];
  assign adc_connect_o = s_q.adc_conn_out;
  assign int0_n_o = s_q.int0_n;
  assign int1_n_o = s_q.int1_n;
  assign xint0_n_o = s_q.xint0_n;
  assign xint1_n_o = s_q.xint1_n;
  assign t0_count_o = s_q.t0_in;
  assign t1_count_o = s_q.t1_in;
  assign rxd_o = s_q.rxd;
  assign vsync_in_o = s_q.vsync_in;

endmodule

`default_nettype wire

// ===== pmx_port_mux_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module pmx_port_mux_asserts (
  // clock, reset and bus handshake
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // pads
  input wire logic [7:0] port_zero_o,
  input wire logic [7:0] port_one_oe_n_o,
  input wire logic [7:0] port_three_i,
  input wire logic [7:0] port_three_o,
  input wire logic [7:0] port_three_oe_n_o,
  // routed signals
  input wire logic txd_i,
  input wire logic int0_n_o,
  input wire logic t0_count_o,
  input wire logic rxd_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // bus answers exactly one cycle after a request and never holds ack
  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  // reset has to win over everything, so no disable here
  property p_reset_vals;
    @(posedge clk_i) disable iff (1'b0)
      rst_i |=> port_one_oe_n_o == 8'hff && port_three_oe_n_o == 8'hff;
  endproperty
  property p_zero_od;
    port_zero_o == 8'h00;
  endproperty
  // strong high only right after a low latch, and only for one cycle
  property p_pulse_len;
    !port_three_oe_n_o[6] && port_three_o[6] |=> port_three_oe_n_o[6];
  endproperty
  property p_pulse_cause;
    !port_three_oe_n_o[6] && port_three_o[6] |->
      !$past(port_three_oe_n_o[6]) && !$past(port_three_o[6]);
  endproperty
  // two driven cycles in a row rule out the one-cycle pulse
  property p_txd;
    !port_three_oe_n_o[1] ##1 !port_three_oe_n_o[1] |-> $past(port_three_o[1]) == $past(txd_i, 2);
  endproperty
  property p_int0_sync;
    port_three_oe_n_o[2] [*4] |-> int0_n_o == $past(port_three_i[2], 3);
  endproperty
  property p_rxd_sync;
    port_three_oe_n_o[7] [*4] |-> rxd_o == $past(port_three_i[7], 3);
  endproperty
  property p_t0_idle;
    !port_three_oe_n_o[4] && !port_three_o[4] |-> t0_count_o;
  endproperty

  a_ack_resp: assert property (p_ack_resp) else $error("bus request not answered");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");
  a_reset_vals: assert property (p_reset_vals) else $error("pads not released in reset");
  a_zero_od: assert property (p_zero_od) else $error("port zero drove high");
  a_pulse_len: assert property (p_pulse_len) else $error("strong high too long");
  a_pulse_cause: assert property (p_pulse_cause) else $error("strong high without low");
  a_txd: assert property (p_txd) else $error("transmit not routed to pad");
  a_int0_sync: assert property (p_int0_sync) else $error("interrupt 0 level wrong");
  a_rxd_sync: assert property (p_rxd_sync) else $error("receive level wrong");
  a_t0_idle: assert property (p_t0_idle) else $error("timer input not idle");

  c_ack: cover property (wb_ack_o);
  c_pulse: cover property (!port_three_oe_n_o[6] && port_three_o[6]);
  c_txd: cover property (!port_three_oe_n_o[1] [*3]);
endmodule

`default_nettype wire

// ===== pmx_pin_model.sv
`timescale 1ns/10ps
`default_nettype none

module pmx_pin_model (
  // pad drive from the block
  input wire logic [7:0] drv_i,
  input wire logic [7:0] drv_oe_n_i,
  // outside level, all ones stands for the pull-up when nothing drives
  input wire logic [7:0] ext_i,
  output logic [7:0] pin_o
);
  // a driven pad overrides the weak outside source
  assign pin_o = (drv_oe_n_i & ext_i) | (~drv_oe_n_i & drv_i);
endmodule

`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmx_regs.svh"

module tb_top;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, ext0, ext1, ext3, ext4;
  logic [3:0] wb_sel_i, port_two_i, adc_connect_o;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [7:0] port_zero_i, port_zero_o, port_zero_oe_n_o, port_one_i, port_one_o, port_one_oe_n_o;
  logic [7:0] port_three_i, port_three_o, port_three_oe_n_o;
  logic [7:0] port_four_i, port_four_o, port_four_oe_n_o;
  logic [5:0] pwm8_i;
  logic [1:0] pwm14_i;
  logic [2:0] addr_hi_i;
  logic odd_even_i, rd_strobe_n_i, wr_strobe_n_i, vsync_i;
  logic txd_i = 1'b0;
  logic int0_n_o, int1_n_o, xint0_n_o, xint1_n_o, t0_count_o, t1_count_o, rxd_o, vsync_in_o;
  int bad_count, checks;

  // outside circuitry on each latched port
  pmx_pin_model m0 (.drv_i(port_zero_o), .drv_oe_n_i(port_zero_oe_n_o), .ext_i(ext0),
    .pin_o(port_zero_i));
  pmx_pin_model m1 (.drv_i(port_one_o), .drv_oe_n_i(port_one_oe_n_o), .ext_i(ext1),
    .pin_o(port_one_i));
  pmx_pin_model m3 (.drv_i(port_three_o), .drv_oe_n_i(port_three_oe_n_o), .ext_i(ext3),
    .pin_o(port_three_i));
  pmx_pin_model m4 (.drv_i(port_four_o), .drv_oe_n_i(port_four_oe_n_o), .ext_i(ext4),
    .pin_o(port_four_i));

  pmx_port_mux dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .port_zero_i, .port_zero_o, .port_zero_oe_n_o,
    .port_one_i, .port_one_o, .port_one_oe_n_o, .port_two_i, .port_three_i, .port_three_o,
    .port_three_oe_n_o, .port_four_i, .port_four_o, .port_four_oe_n_o, .pwm8_i, .pwm14_i,
    .odd_even_i, .txd_i, .addr_hi_i, .rd_strobe_n_i, .wr_strobe_n_i, .vsync_i,
    .adc_connect_o, .int0_n_o, .int1_n_o, .xint0_n_o, .xint1_n_o, .t0_count_o, .t1_count_o,
    .rxd_o, .vsync_in_o);

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // transmit line toggles so a stale pad value shows
  always @(posedge clk_i) txd_i <= ~txd_i;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic cycle; returns at the falling edge after ack so pads can be looked at
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    if (n >= 50) chk("bus ack", 32'(wb_ack_o), 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(negedge clk_i);
  endtask

  function automatic logic [7:0] rmw(input logic [3:0] op, input logic [7:0] l,
    input logic [7:0] v, input logic [2:0] b);
    logic [7:0] m;
    m = 8'h01 << b;
    case (op)
      4'h0: return l & v;
      4'h1: return l | v;
      4'h2: return l ^ v;
      4'h3: return l + 8'h01;
      4'h4: return l - 8'h01;
      4'h5: return l ^ m;
      4'h6, 4'h9: return l & ~m;
      4'h7: return l | m;
      4'h8: return v[0] ? (l | m) : (l & ~m);
      default: return l;
    endcase
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    chk("watchdog", 32'h0, 32'h1);
    end_sim();
  end

  initial begin
    bad_count = 0;
    checks = 0;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    port_two_i = 4'hf;
    pwm8_i = 6'h15;
    pwm14_i = 2'h1;
    addr_hi_i = 3'h5;
    odd_even_i = 1'b0;
    rd_strobe_n_i = 1'b0;
    wr_strobe_n_i = 1'b1;
    vsync_i = 1'b1;
    ext0 = 8'hff;
    ext1 = 8'h00;
    ext3 = 8'hff;
    ext4 = 8'hff;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk("p1 oe_n", 32'(port_one_oe_n_o), 32'hff);
    chk("p4 oe_n", 32'(port_four_oe_n_o), 32'hec);
    chk("p4 addr", 32'(port_four_o & 8'h13), 32'h11);
    wb(1'b0, `PMX_ADR_PORT_THREE, 32'h0, 4'hf);
    chk("p3 latch", rd, 32'hff);
    wb(1'b0, 8'h3c, 32'h0, 4'hf);
    chk("unmapped", rd, 32'h0);
    $display("test reset done");
    // pins held low so a pin read would differ from the latch
    for (int op = 0; op < 11; op++) begin
      wb(1'b1, `PMX_ADR_PORT_ONE, 32'h5a, 4'h1);
      wb(1'b1, `PMX_ADR_RMW_CMD, {15'h0, 4'(op), 2'h1, 3'(op), 8'h33}, 4'hf);
      wb(1'b0, `PMX_ADR_RMW_RES, 32'h0, 4'hf);
      chk("rmw", rd, {16'h0, rmw(4'(op), 8'h5a, 8'h33, 3'(op)), 8'h5a});
    end
    @(posedge clk_i) ext1 <= 8'h3c;
    wb(1'b1, `PMX_ADR_PORT_ONE, 32'h0f, 4'h1);
    // old low pads and the pulse must clear the synchroniser before the pin read
    repeat (3) @(negedge clk_i);
    wb(1'b0, `PMX_ADR_PORT_ONE, 32'h0, 4'hf);
    chk("p1 read", rd, 32'h0c);
    wb(1'b1, `PMX_ADR_PORT_ZERO, 32'h3c, 4'h1);
    chk("p0 oe_n", 32'(port_zero_oe_n_o), 32'h3c);
    wb(1'b0, `PMX_ADR_PORT_ZERO, 32'h0, 4'hf);
    chk("p0 read", rd, 32'h3c);
    $display("test latch done");
    wb(1'b1, `PMX_ADR_PORT_THREE, 32'hbf, 4'h1);
    wb(1'b1, `PMX_ADR_PORT_THREE, 32'hff, 4'h1);
    chk("pulse", 32'({port_three_oe_n_o[6], port_three_o[6]}), 32'h1);
    @(negedge clk_i);
    chk("pulse end", 32'(port_three_oe_n_o), 32'hff);
    @(posedge clk_i) ext3 <= 8'h00;
    repeat (4) @(negedge clk_i);
    chk("p3 in", 32'({int0_n_o, int1_n_o, xint0_n_o, xint1_n_o, t0_count_o, t1_count_o,
      rxd_o}), 32'h0);
    wb(1'b1, `PMX_ADR_PORT_THREE, 32'h00, 4'h1);
    repeat (4) @(negedge clk_i);
    chk("p3 out", 32'({int0_n_o, int1_n_o, xint0_n_o, xint1_n_o, t0_count_o, t1_count_o,
      rxd_o}), 32'h7f);
    wb(1'b1, `PMX_ADR_PORT_THREE, 32'hff, 4'h1);
    @(posedge clk_i) ext3 <= 8'hff;
    $display("test port three done");
    wb(1'b1, `PMX_ADR_PORT_ONE, 32'hff, 4'h1);
    wb(1'b1, `PMX_ADR_PWM_OE, 32'h81, 4'h1);
    chk("pwm oe_n", 32'(port_one_oe_n_o), 32'h7e);
    chk("pwm out", 32'(port_one_o & 8'h81), 32'h01);
    wb(1'b0, `PMX_ADR_PWM_OE, 32'h0, 4'hf);
    chk("pwm reg", rd, 32'h81);
    wb(1'b1, `PMX_ADR_ADC_CONN, 32'h5, 4'h1);
    chk("adc", 32'(adc_connect_o), 32'h5);
    wb(1'b0, `PMX_ADR_PORT_TWO, 32'h0, 4'hf);
    chk("p2 read", rd, 32'ha);
    wb(1'b1, `PMX_ADR_CSC_ZERO, 32'h1, 4'h1);
    chk("odd even", 32'({port_three_oe_n_o[0], port_three_o[0]}), 32'h0);
    wb(1'b1, `PMX_ADR_CSC_ONE, 32'hf, 4'h1);
    chk("p4 pins", 32'(port_four_oe_n_o), 32'hf3);
    chk("strobes", 32'(port_four_o & 8'h0c), 32'h08);
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, `PMX_ADR_CSC_ZERO, i ? 32'h6 : 32'h2, 4'h1);
      chk("vsync out", 32'({port_four_oe_n_o[7], port_four_o[7]}), i ? 32'h0 : 32'h1);
    end
    wb(1'b1, `PMX_ADR_CSC_ZERO, 32'h0, 4'h1);
    @(posedge clk_i) ext4 <= 8'h7f;
    repeat (4) @(negedge clk_i);
    chk("vsync in", 32'(vsync_in_o), 32'h0);
    $display("test routing done");
    end_sim();
  end
endmodule

bind pmx_port_mux pmx_port_mux_asserts u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .port_zero_o, .port_one_oe_n_o, .port_three_i, .port_three_o, .port_three_oe_n_o, .txd_i,
  .int0_n_o, .t0_count_o, .rxd_o);

`default_nettype wire
